// *** hw/fptr_pkg.sv ***
// Purpose: Constants for the front panel trigger router.
// Assumes: Eight backplane trigger lines on each of segments 2 and 3.
// Notes: Each port drives its pin, or fans its pin out to trigger lines.
// Notes on behaviour
// - Output port driven from one selected line.
// - Input port drives any lines, either segment.
// - Output port pin held idle while out_enable is low; changes apply at the next edge.
// - Input with no lines selected drives nothing.
// - Output pin is push-pull, never open-drain.
// - Inter-segment route silently disables input fanout.
package fptr_pkg;
  // ----------------------------------------------------------------
  // Sizes and encodings
  // ----------------------------------------------------------------
  localparam int FPTR_LINES = 8;
  localparam int FPTR_PORTS = 2;
  localparam int FPTR_SEL_W = 3;
  // Segment select of an output port.
  localparam logic FPTR_SEG2 = 1'h0;
  localparam logic FPTR_SEG3 = 1'h1;
  // Direction of a port.
  localparam logic FPTR_DIR_IN = 1'h0;
  localparam logic FPTR_DIR_OUT = 1'h1;
  // Reset values and the inactive pin level.
  localparam logic [7:0] FPTR_NO_LINES = 8'h00;
  localparam logic FPTR_IDLE_LEVEL = 1'h0;
endpackage : fptr_pkg

// *** hw/fptr_router.sv ***
// Purpose: Routes two front panel trigger pins to backplane lines.
// Assumes: Configuration bits come from logic on clk; pins and lines
//          are asynchronous and are synchronised here.
// Notes: Every output comes from a flip-flop, so a change shows three
//        edges after a pin moves and one edge after a config change.
`timescale 1ns/1ns
module fptr_router
  import fptr_pkg::*;
#(
  parameter int PORTS = FPTR_PORTS,
  parameter int LINES = FPTR_LINES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Port configuration, per port, and the shared route_2_3_active
  input wire logic [PORTS-1:0] port_dir,
  input wire logic [PORTS-1:0] out_enable,
  input wire logic [PORTS-1:0] out_seg,
  input wire logic [PORTS*FPTR_SEL_W-1:0] out_line,
  input wire logic [PORTS*LINES-1:0] in_mask_seg2,
  input wire logic [PORTS*LINES-1:0] in_mask_seg3,
  input wire logic route_2_3_active,
  // Front panel pins
  input wire logic [PORTS-1:0] pin_in,
  output logic [PORTS-1:0] pin_out,
  output logic [PORTS-1:0] pin_oe,
  // Backplane trigger lines, segment 2 and segment 3
  input wire logic [LINES-1:0] seg2_in,
  input wire logic [LINES-1:0] seg3_in,
  output logic [LINES-1:0] seg2_out,
  output logic [LINES-1:0] seg2_oe,
  output logic [LINES-1:0] seg3_out,
  output logic [LINES-1:0] seg3_oe
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (LINES != FPTR_LINES || PORTS < 1) begin : g_bad
    $error("fptr_router: unsupported LINES or PORTS");
  end

  // ----------------------------------------------------------------
  // Synchronisers for pins and lines
  // ----------------------------------------------------------------
  logic [PORTS-1:0] pin_m, pin_s;
  logic [LINES-1:0] s2_m, s2_s, s3_m, s3_s;

  // Two flops each; only the second stage is read by logic.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_m <= '0;
      pin_s <= '0;
      s2_m <= '0;
      s2_s <= '0;
      s3_m <= '0;
      s3_s <= '0;
    end else begin
      pin_m <= pin_in;
      pin_s <= pin_m;
      s2_m <= seg2_in;
      s2_s <= s2_m;
      s3_m <= seg3_in;
      s3_s <= s3_m;
    end
  end

  // ----------------------------------------------------------------
  // Field decoding shared by the drive paths
  // ----------------------------------------------------------------
  // Lines that input port p asks for in one packed mask vector.
  function automatic logic [LINES-1:0] mask_of(
    input logic [PORTS*LINES-1:0] masks,
    input int p
  );
    return masks[p*LINES +: LINES];
  endfunction : mask_of

  // Level of the line that output port p copies from one segment.
  function automatic logic line_pick(
    input logic [LINES-1:0] lines,
    input logic [PORTS*FPTR_SEL_W-1:0] sel,
    input int p
  );
    return lines[sel[p*FPTR_SEL_W +: FPTR_SEL_W]];
  endfunction : line_pick

  // ----------------------------------------------------------------
  // Next values of line and pin drive
  // ----------------------------------------------------------------
  logic [LINES-1:0] next_s2_oe, next_s3_oe, next_s2_out, next_s3_out;
  logic [PORTS-1:0] next_pin_out, next_pin_oe;

  // Fan each input port out onto its selected lines on either segment while route_2_3_active is low.
  always_comb begin
    next_s2_oe = FPTR_NO_LINES;
    next_s3_oe = FPTR_NO_LINES;
    next_s2_out = FPTR_NO_LINES;
    next_s3_out = FPTR_NO_LINES;
    for (int p = 0; p < PORTS; p++) begin
      if (port_dir[p] == FPTR_DIR_IN && !route_2_3_active) begin
        // Empty masks add no line to this port's drive.
        next_s2_oe = next_s2_oe | mask_of(in_mask_seg2, p);
        next_s3_oe = next_s3_oe | mask_of(in_mask_seg3, p);
        if (pin_s[p]) begin
          next_s2_out = next_s2_out | mask_of(in_mask_seg2, p);
          next_s3_out = next_s3_out | mask_of(in_mask_seg3, p);
        end
      end
    end
  end

  // Output ports copy one selected line; the pin is always driven.
  always_comb begin
    next_pin_out = '0;
    next_pin_oe = '0;
    for (int p = 0; p < PORTS; p++) begin
      if (port_dir[p] == FPTR_DIR_OUT) begin
        next_pin_oe[p] = 1'h1;
        if (!out_enable[p]) begin
          next_pin_out[p] = FPTR_IDLE_LEVEL;
        end else if (out_seg[p] == FPTR_SEG2) begin
          next_pin_out[p] = line_pick(s2_s, out_line, p);
        end else begin
          next_pin_out[p] = line_pick(s3_s, out_line, p);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output registers, updated every cycle with no commit step
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      seg2_oe <= FPTR_NO_LINES;
      seg3_oe <= FPTR_NO_LINES;
      seg2_out <= FPTR_NO_LINES;
      seg3_out <= FPTR_NO_LINES;
    end else begin
      seg2_oe <= next_s2_oe;
      seg3_oe <= next_s3_oe;
      seg2_out <= next_s2_out;
      seg3_out <= next_s3_out;
    end
  end

  // Pin drive register.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Checks that look one edge back skip an edge that applied reset, since
  // the registers then hold reset values, not the configured ones.
  chk_out_push_pull: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $past(port_dir[0]) == FPTR_DIR_OUT |-> pin_oe[0])
    else $error("output port not driven");
  chk_in_no_pin: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $past(port_dir[0]) == FPTR_DIR_IN |-> !pin_oe[0])
    else $error("input port pin driven");
  chk_top_port_oe: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $past(port_dir[PORTS-1]) == FPTR_DIR_OUT
      |-> pin_oe[PORTS-1])
    else $error("last output port not driven");
  chk_empty_mask: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $past(in_mask_seg2) == '0 && $past(in_mask_seg3) == '0
      |-> seg2_oe == '0 && seg3_oe == '0)
    else $error("line driven with empty masks");
  chk_route_off: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $past(route_2_3_active)
      |-> seg2_oe == '0 && seg3_oe == '0)
    else $error("input fanout not disabled by route");
  chk_fan_seg2: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $past(port_dir[0]) == FPTR_DIR_IN
      && !$past(route_2_3_active)
      |-> (seg2_oe & $past(in_mask_seg2[LINES-1:0]))
        == $past(in_mask_seg2[LINES-1:0]))
    else $error("segment 2 fanout missing");
  chk_fan_seg3: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $past(port_dir[0]) == FPTR_DIR_IN
      && !$past(route_2_3_active)
      |-> (seg3_oe & $past(in_mask_seg3[LINES-1:0]))
        == $past(in_mask_seg3[LINES-1:0]))
    else $error("segment 3 fanout missing");

  // While route_2_3_active is low, a high input pin shows as a high level on every line it selects.
  chk_drive_seg2: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $past(port_dir[0]) == FPTR_DIR_IN
      && !$past(route_2_3_active) && $past(pin_s[0])
      |-> (seg2_out & $past(in_mask_seg2[LINES-1:0]))
        == $past(in_mask_seg2[LINES-1:0]))
    else $error("segment 2 line not driven high");
  chk_drive_seg3: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $past(port_dir[0]) == FPTR_DIR_IN
      && !$past(route_2_3_active) && $past(pin_s[0])
      |-> (seg3_out & $past(in_mask_seg3[LINES-1:0]))
        == $past(in_mask_seg3[LINES-1:0]))
    else $error("segment 3 line not driven high");
  // No line carries a high level unless its drive enable is set.
  chk_drive_gated: assert property (@(posedge clk) disable iff (!rstn)
    (seg2_out & ~seg2_oe) == '0 && (seg3_out & ~seg3_oe) == '0)
    else $error("line level without drive enable");

  chk_idle_level: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $past(port_dir[0]) == FPTR_DIR_OUT
      && !$past(out_enable[0])
      |-> pin_out[0] == FPTR_IDLE_LEVEL)
    else $error("disabled output not idle");
  chk_out_follow: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $past(port_dir[0]) == FPTR_DIR_OUT
      && $past(out_enable[0]) && $past(out_seg[0]) == FPTR_SEG2
      |-> pin_out[0] == $past(s2_s[out_line[FPTR_SEL_W-1:0]]))
    else $error("output pin not following line");
  chk_out_seg3: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $past(port_dir[0]) == FPTR_DIR_OUT
      && $past(out_enable[0]) && $past(out_seg[0]) == FPTR_SEG3
      |-> pin_out[0] == $past(s3_s[out_line[FPTR_SEL_W-1:0]]))
    else $error("output pin not following segment 3 line");

  // Port 0 turns from input to output and stays an output a cycle.
  sequence seq_turn_out;
    rstn && $past(port_dir[0]) == FPTR_DIR_IN
      && port_dir[0] == FPTR_DIR_OUT
      ##1 port_dir[0] == FPTR_DIR_OUT;
  endsequence : seq_turn_out

  chk_cfg_immediate: assert property (@(posedge clk) disable iff (!rstn)
    seq_turn_out |-> pin_oe[0])
    else $error("direction change delayed");
  // An edge in reset leaves nothing driven at the next edge.
  chk_reset_quiet: assert property (@(posedge clk)
    !rstn |=> pin_oe == '0 && pin_out == '0
      && seg2_oe == '0 && seg3_oe == '0)
    else $error("output driven after reset edge");
endmodule : fptr_router

// *** testbench/fptr_far_model.sv ***
// Purpose: Plug-in modules that share the backplane trigger lines.
// Assumes: Modules hold their level on every line the router leaves free.
// Notes: No link to segment 1 is modelled.
`timescale 1ns/1ns
module fptr_far_model (
  // Levels the modules would drive, segment 3 above segment 2
  input wire logic [15:0] lvl,
  // Router drive of the lines
  input wire logic [7:0] s2_out,
  input wire logic [7:0] s2_oe,
  input wire logic [7:0] s3_out,
  input wire logic [7:0] s3_oe,
  // Resolved line levels
  output logic [7:0] seg2_in,
  output logic [7:0] seg3_in
);
  // Modules back off any line the router drives, so a line has one source.
  assign seg2_in = (s2_oe & s2_out) | (~s2_oe & lvl[7:0]);
  assign seg3_in = (s3_oe & s3_out) | (~s3_oe & lvl[15:8]);
endmodule : fptr_far_model

// *** testbench/fptr_router_tb_top.sv ***
// Purpose: Random configurations of the trigger router, checked in full.
// Assumes: Config shows one edge later, pin paths within ten edges.
// Notes: Drive enables are checked at once, levels after settling.
`timescale 1ns/1ns
module fptr_router_tb_top;
  import fptr_pkg::*;
  logic clk = 0, rstn = 0, route = 0;
  logic [1:0] dir = 0, en = 0, seg = 0, pin = 0, pin_out, pin_oe;
  logic [5:0] line = 0;
  logic [15:0] m2 = 0, m3 = 0, lvl = 0;
  logic [7:0] s2o, s2e, s3o, s3e, s2i, s3i;
  logic [36:0] q[$];
  int n_fail = 0, n_compared = 0, cyc = 0;
  event ev;
  initial forever #10 clk = ~clk;
  fptr_router i_dut (.clk(clk), .rstn(rstn), .port_dir(dir),
    .out_enable(en), .out_seg(seg), .out_line(line), .in_mask_seg2(m2),
    .in_mask_seg3(m3), .route_2_3_active(route), .pin_in(pin),
    .pin_out(pin_out), .pin_oe(pin_oe), .seg2_in(s2i), .seg3_in(s3i),
    .seg2_out(s2o), .seg2_oe(s2e), .seg3_out(s3o), .seg3_oe(s3e));
  fptr_far_model i_far (.lvl(lvl), .s2_out(s2o), .s2_oe(s2e),
    .s3_out(s3o), .s3_oe(s3e), .seg2_in(s2i), .seg3_in(s3i));
  // Expected outputs worked out from the present configuration.
  function automatic logic [35:0] expect_all();
    logic [7:0] e2, e3, o2, o3, l2, l3;
    logic [1:0] pe, po;
    {e2, e3, o2, o3, pe, po} = '0;
    for (int p = 0; p < 2; p++) begin
      if (dir[p] == FPTR_DIR_IN && !route) begin
        e2 |= m2[p*8+:8];
        e3 |= m3[p*8+:8];
        o2 |= m2[p*8+:8] & {8{pin[p]}};
        o3 |= m3[p*8+:8] & {8{pin[p]}};
      end
    end
    l2 = (e2 & o2) | (~e2 & lvl[7:0]);
    l3 = (e3 & o3) | (~e3 & lvl[15:8]);
    for (int p = 0; p < 2; p++) begin
      pe[p] = (dir[p] == FPTR_DIR_OUT);
      po[p] = pe[p] & en[p] & ((seg[p] == FPTR_SEG3) ? l3[line[p*3+:3]] :
        l2[line[p*3+:3]]);
    end
    return {pe, po, e2, o2, e3, o3};
  endfunction : expect_all
  task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // Takes the oldest note and compares it with the outputs.
  always @(ev) begin : watch
    logic [36:0] x;
    x = q.pop_front();
    cmp("pin_oe", x[35:34], pin_oe);
    cmp("seg2_oe", x[31:24], s2e);
    cmp("seg3_oe", x[15:8], s3e);
    if (x[36]) begin
      cmp("pin_out", x[33:32], pin_out & pin_oe);
      cmp("seg2_out", x[23:16], s2o & s2e);
      cmp("seg3_out", x[7:0], s3o & s3e);
    end
  end
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      n_fail++;
      summarize();
    end
  end
  // Random configurations, each checked one edge on and after settling.
  initial begin
    void'($urandom(32'h11b05a18));
    repeat (5) @(posedge clk);
    #1 q.push_back({1'b1, expect_all()});
    -> ev;
    @(posedge clk);
    rstn <= 1'h1;
    for (int t = 0; t < 60; t++) begin
      if (t == 30) begin
        // Reset in mid-run: every drive must drop.
        @(posedge clk);
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        #1 q.push_back({1'b1, 36'h0});
        -> ev;
        @(posedge clk);
        rstn <= 1'h1;
        $display("test reset done");
      end
      @(posedge clk);
      {dir, en, seg, pin} <= 8'($urandom);
      line <= 6'($urandom);
      m2 <= (t % 5 == 0) ? 16'h0000 : 16'($urandom);
      m3 <= (t % 10 == 0) ? 16'h0000 : 16'($urandom);
      route <= ($urandom % 4 == 0);
      lvl <= 16'($urandom);
      @(posedge clk);
      #1 q.push_back({1'b0, expect_all()});
      -> ev;
      repeat (10) @(posedge clk);
      #1 q.push_back({1'b1, expect_all()});
      -> ev;
      $display("test %0d done", t);
    end
    summarize();
  end
endmodule : fptr_router_tb_top
